// [mode_cfg_pkg.sv]
// Constants, load targets and carrier types for the mode and port configuration bank.
// Assumes one 20 MHz oscillator clock and a core decoder that names the target of each load.

`default_nettype none

package mode_cfg_pkg;

    // -------------------------------------------------------------------
    // Widths and field positions
    // -------------------------------------------------------------------
    localparam int unsigned NIB_W        = 4;
    localparam int unsigned OPC_W        = 16;
    localparam int unsigned RAM_ADDR_W   = 7;
    localparam int unsigned PAGE_W       = 3;
    localparam int unsigned PAGE_SHIFT   = 4;

    localparam int unsigned T0_CLK_SEL   = 0;
    localparam int unsigned T0_RUN       = 3;
    localparam int unsigned T1_RATE_SEL  = 0;
    localparam int unsigned T1_SRC_SEL   = 1;
    localparam int unsigned T1_MFP_SEL   = 2;
    localparam int unsigned T1_RUN       = 3;
    localparam int unsigned DRV_A_OD     = 0;
    localparam int unsigned DRV_B_OD     = 1;
    localparam int unsigned DRV_C_PULL   = 2;
    localparam int unsigned DRV_D_PULL   = 3;

    // Reserved bits are masked away on load
    localparam logic [3:0] T0_MASK       = 4'h9;
    localparam logic [3:0] PAGE_MASK     = 4'h7;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [3:0] ZERO_RST      = 4'h0;
    localparam logic [3:0] DIR_RST       = 4'hf;

    // -------------------------------------------------------------------
    // Clock rates
    // -------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ   = 20_000_000;
    localparam int unsigned DIV_T0_FAST  = 4;
    localparam int unsigned DIV_T1_SLOW  = 64;
    localparam int unsigned DIV_T0_SLOW  = 1024;

    typedef enum logic [2:0] {
        TGT_TIMER0 = 3'h0,
        TGT_TIMER1 = 3'h1,
        TGT_PAGE   = 3'h2,
        TGT_PC_CHG = 3'h3,
        TGT_DRIVE  = 3'h4,
        TGT_DIR_A  = 3'h5,
        TGT_DIR_B  = 3'h6
    } load_target_type;

    typedef struct packed {
        logic                  en;
        load_target_type       target;
        logic [OPC_W-1:0]      opcode;
    } load_req_type;

    typedef struct packed {
        logic d_pullup;
        logic c_pullup;
        logic b_open_drain;
        logic a_open_drain;
    } drive_cfg_type;

endpackage : mode_cfg_pkg
`default_nettype wire

// [osc_prescaler.sv]
// Free-running oscillator prescaler giving one-cycle enable pulses.
// Assumes the oscillator clock is the only clock; all slower rates are enables.
`timescale 1ns/1ns
`default_nettype none

module osc_prescaler #(
    parameter int unsigned DIV_A = 4,
    parameter int unsigned DIV_B = 64,
    parameter int unsigned DIV_C = 1024
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    output var  logic tick_a,
    output var  logic tick_b,
    output var  logic tick_c
);

    localparam int unsigned CNT_W = $clog2(DIV_C);

    logic [CNT_W-1:0] cnt_r;

    // -------------------------------------------------------------------
    // Counter
    // -------------------------------------------------------------------
    // Power-of-two dividers share one counter, so all taps stay in phase
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tick_a <= 1'b0;
            tick_b <= 1'b0;
            tick_c <= 1'b0;
        end else begin
            tick_a <= (cnt_r[$clog2(DIV_A)-1:0] == {$clog2(DIV_A){1'b1}});
            tick_b <= (cnt_r[$clog2(DIV_B)-1:0] == {$clog2(DIV_B){1'b1}});
            tick_c <= (cnt_r == {CNT_W{1'b1}});
        end
    end

endmodule : osc_prescaler
`default_nettype wire

// [mode_cfg_bank.sv]
// Write-only 4-bit mode registers loaded by load-immediate instructions.
// Assumes the core decoder presents one load request per machine cycle,
// and that port C pins and the timer1 pin clock arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

module mode_cfg_bank (
    input  wire logic                              sys_clk,
    input  wire logic                              rstn,
    input  wire mode_cfg_pkg::load_req_type        load_req,
    input  wire logic                              mfp_gen_wave,
    input  wire logic                              timer1_freq_out,
    input  wire logic                              port_c_pin0_clock_in,
    input  wire logic [mode_cfg_pkg::NIB_W-1:0]    port_c_in,
    input  wire logic [mode_cfg_pkg::NIB_W-1:0]    port_a_data,
    input  wire logic [mode_cfg_pkg::NIB_W-1:0]    port_b_data,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    timer0_mode,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    timer1_mode,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    indirect_page_select,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_c_change_enable,
    output var  mode_cfg_pkg::drive_cfg_type       port_drive_config,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_a_direction,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_b_direction,
    output var  logic                              timer0_count_en,
    output var  logic                              timer1_count_en,
    output var  logic                              modulated_freq_pin,
    output var  logic [mode_cfg_pkg::RAM_ADDR_W-1:0] indirect_page_base,
    output var  logic                              port_c_change_event,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_a_out,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_a_oe,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_b_out,
    output var  logic [mode_cfg_pkg::NIB_W-1:0]    port_b_oe
);

    logic [mode_cfg_pkg::NIB_W-1:0] imm;
    logic                           tick_div4;
    logic                           tick_div64;
    logic                           tick_div1024;
    logic                           t1_pin_s1_r;
    logic                           t1_pin_s2_r;
    logic                           t1_pin_prev_r;
    logic                           t1_pin_fall;
    logic                           t1_int_tick;
    logic [mode_cfg_pkg::NIB_W-1:0] pc_s1_r;
    logic [mode_cfg_pkg::NIB_W-1:0] pc_s2_r;
    logic [mode_cfg_pkg::NIB_W-1:0] pc_prev_r;
    logic [mode_cfg_pkg::NIB_W-1:0] pc_changed;

    // -------------------------------------------------------------------
    // Prescaler
    // -------------------------------------------------------------------
    osc_prescaler #(
        .DIV_A (mode_cfg_pkg::DIV_T0_FAST),
        .DIV_B (mode_cfg_pkg::DIV_T1_SLOW),
        .DIV_C (mode_cfg_pkg::DIV_T0_SLOW)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tick_a  (tick_div4),
        .tick_b  (tick_div64),
        .tick_c  (tick_div1024)
    );

    // -------------------------------------------------------------------
    // Register loads
    // -------------------------------------------------------------------
    assign imm = load_req.opcode[mode_cfg_pkg::NIB_W-1:0];

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer0_mode <= mode_cfg_pkg::ZERO_RST;
        end else if (load_req.en && load_req.target == mode_cfg_pkg::TGT_TIMER0) begin
            timer0_mode <= imm & mode_cfg_pkg::T0_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer1_mode <= mode_cfg_pkg::ZERO_RST;
        end else if (load_req.en && load_req.target == mode_cfg_pkg::TGT_TIMER1) begin
            timer1_mode <= imm;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            indirect_page_select <= mode_cfg_pkg::ZERO_RST;
        end else if (load_req.en && load_req.target == mode_cfg_pkg::TGT_PAGE) begin
            indirect_page_select <= imm & mode_cfg_pkg::PAGE_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port_c_change_enable <= mode_cfg_pkg::ZERO_RST;
        end else if (load_req.en && load_req.target == mode_cfg_pkg::TGT_PC_CHG) begin
            port_c_change_enable <= imm;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port_drive_config <= mode_cfg_pkg::drive_cfg_type'(mode_cfg_pkg::ZERO_RST);
        end else if (load_req.en && load_req.target == mode_cfg_pkg::TGT_DRIVE) begin
            port_drive_config <= mode_cfg_pkg::drive_cfg_type'(imm);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port_a_direction <= mode_cfg_pkg::DIR_RST;
            port_b_direction <= mode_cfg_pkg::DIR_RST;
        end else if (load_req.en) begin
            if (load_req.target == mode_cfg_pkg::TGT_DIR_A) begin
                port_a_direction <= imm;
            end
            if (load_req.target == mode_cfg_pkg::TGT_DIR_B) begin
                port_b_direction <= imm;
            end
        end
    end

    // -------------------------------------------------------------------
    // Timer clock selection
    // -------------------------------------------------------------------
    // The pin clock counts on its falling edge; the first synchroniser stage feeds only the second
    // No reset on the chain: it keeps tracking the pin, so release never shows a false edge
    // Limitation: reset must last three cycles for the chain to settle on the pin level
    always_ff @(posedge sys_clk) begin
        t1_pin_s1_r   <= port_c_pin0_clock_in;
        t1_pin_s2_r   <= t1_pin_s1_r;
        t1_pin_prev_r <= t1_pin_s2_r;
    end

    assign t1_pin_fall = t1_pin_prev_r & ~t1_pin_s2_r;
    assign t1_int_tick = timer1_mode[mode_cfg_pkg::T1_RATE_SEL] ? tick_div64 : 1'b1;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer0_count_en <= 1'b0;
        end else begin
            timer0_count_en <= timer0_mode[mode_cfg_pkg::T0_RUN]
                             & (timer0_mode[mode_cfg_pkg::T0_CLK_SEL] ? tick_div1024 : tick_div4);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer1_count_en <= 1'b0;
        end else begin
            timer1_count_en <= timer1_mode[mode_cfg_pkg::T1_RUN]
                             & (timer1_mode[mode_cfg_pkg::T1_SRC_SEL] ? t1_pin_fall : t1_int_tick);
        end
    end

    // -------------------------------------------------------------------
    // Output pin routing and page base
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            modulated_freq_pin <= 1'b0;
        end else begin
            modulated_freq_pin <= timer1_mode[mode_cfg_pkg::T1_MFP_SEL] ? timer1_freq_out : mfp_gen_wave;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            indirect_page_base <= '0;
        end else begin
            indirect_page_base <= {indirect_page_select[mode_cfg_pkg::PAGE_W-1:0],
                                   {mode_cfg_pkg::PAGE_SHIFT{1'b0}}};
        end
    end

    // -------------------------------------------------------------------
    // Port C change detection
    // -------------------------------------------------------------------
    // Previous value is always tracked, so enabling a pin never reports a stale change
    // Not reset either: a pulled-high pin must not look like a change just after reset
    always_ff @(posedge sys_clk) begin
        pc_s1_r   <= port_c_in;
        pc_s2_r   <= pc_s1_r;
        pc_prev_r <= pc_s2_r;
    end

    assign pc_changed = (pc_s2_r ^ pc_prev_r) & port_c_change_enable;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            port_c_change_event <= 1'b0;
        end else begin
            port_c_change_event <= |pc_changed;
        end
    end

    // -------------------------------------------------------------------
    // Port A and B pad control
    // -------------------------------------------------------------------
    // Open-drain pins only drive low; a high bit releases the pad
    genvar gi;
    generate
        for (gi = 0; gi < mode_cfg_pkg::NIB_W; gi++) begin : g_pad
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    port_a_out[gi] <= 1'b0;
                    port_a_oe[gi]  <= 1'b0;
                    port_b_out[gi] <= 1'b0;
                    port_b_oe[gi]  <= 1'b0;
                end else begin
                    port_a_out[gi] <= port_a_data[gi];
                    port_a_oe[gi]  <= ~port_a_direction[gi]
                                    & ~(port_drive_config.a_open_drain & port_a_data[gi]);
                    port_b_out[gi] <= port_b_data[gi];
                    port_b_oe[gi]  <= ~port_b_direction[gi]
                                    & ~(port_drive_config.b_open_drain & port_b_data[gi]);
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_load_one_cycle;
        load_req.en && load_req.target == mode_cfg_pkg::TGT_TIMER1
            |=> timer1_mode == $past(load_req.opcode[3:0]);
    endproperty
    a_load_one_cycle: assert property (p_load_one_cycle) else $error("timer1 load missed");

    property p_t0_slow;
        timer0_mode[0] && timer0_mode[3] && $past(timer0_mode[0]) && $past(timer0_mode[3]) && tick_div4
            && !tick_div1024 |=> !timer0_count_en;
    endproperty
    a_t0_slow: assert property (p_t0_slow) else $error("timer0 slow clock ticked early");

    property p_t0_halt;
        !timer0_mode[3] |=> !timer0_count_en;
    endproperty
    a_t0_halt: assert property (p_t0_halt) else $error("timer0 counts while halted");

    property p_t0_reserved;
        timer0_mode[2:1] == 2'b00;
    endproperty
    a_t0_reserved: assert property (p_t0_reserved) else $error("timer0 reserved bits stored");

    property p_t1_fast;
        timer1_mode == 4'h8 |=> timer1_count_en;
    endproperty
    a_t1_fast: assert property (p_t1_fast) else $error("timer1 osc clock missing");

    property p_t1_pin;
        timer1_mode[3] && timer1_mode[1] && !t1_pin_fall |=> !timer1_count_en;
    endproperty
    a_t1_pin: assert property (p_t1_pin) else $error("timer1 pin clock without edge");

    property p_mfp_route;
        timer1_mode[2] |=> modulated_freq_pin == $past(timer1_freq_out);
    endproperty
    a_mfp_route: assert property (p_mfp_route) else $error("output pin not routed from timer1");

    property p_t1_halt;
        !timer1_mode[3] |=> !timer1_count_en;
    endproperty
    a_t1_halt: assert property (p_t1_halt) else $error("timer1 counts while halted");

    property p_page_base;
        $stable(indirect_page_select)[*2] |-> indirect_page_base == {indirect_page_select[2:0], 4'h0};
    endproperty
    a_page_base: assert property (p_page_base) else $error("page base mismatch");

    property p_pc_masked;
        port_c_change_enable == 4'h0 |=> !port_c_change_event;
    endproperty
    a_pc_masked: assert property (p_pc_masked) else $error("masked port C change reported");

    property p_open_drain;
        port_drive_config.a_open_drain && port_a_data[0] |=> !port_a_oe[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin drove high");

    property p_dir_b_in;
        port_b_direction[0] |=> !port_b_oe[0];
    endproperty
    a_dir_b_in: assert property (p_dir_b_in) else $error("input pin on port B driven");

    property p_dir_a;
        port_a_direction[1] |=> !port_a_oe[1];
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("input pin on port A driven");

    property p_dir_b;
        !port_b_direction[2] && !port_drive_config.b_open_drain |=> port_b_oe[2];
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("output pin on port B not driven");

    property p_dir_reset;
        $rose(rstn) |-> port_a_direction == 4'hf && port_b_direction == 4'hf;
    endproperty
    a_dir_reset: assert property (@(posedge sys_clk) p_dir_reset) else $error("directions not inputs");

    property p_pull_load;
        load_req.en && load_req.target == mode_cfg_pkg::TGT_DRIVE
            |=> port_drive_config.c_pullup == $past(load_req.opcode[2]) && port_drive_config.d_pullup == $past(load_req.opcode[3]);
    endproperty
    a_pull_load: assert property (p_pull_load) else $error("pull-up enables not loaded");

endmodule : mode_cfg_bank
`default_nettype wire

// [mode_cfg_bank_tb_top.sv]
// Self-checking testbench for the mode and port configuration bank.
// Assumes the bank alone, driven at its ports; the bench plays the core decoder and the pins.
`timescale 1ns/1ns
`default_nettype none

module mode_cfg_bank_tb_top;

    logic                              sys_clk;
    logic                              rstn;
    mode_cfg_pkg::load_req_type        load_req;
    logic                              mfp_gen_wave;
    logic                              timer1_freq_out;
    logic                              port_c_pin0_clock_in;
    logic [3:0]                        port_c_in;
    logic [3:0]                        port_a_data;
    logic [3:0]                        port_b_data;
    logic [3:0]                        timer0_mode;
    logic [3:0]                        timer1_mode;
    logic [3:0]                        indirect_page_select;
    logic [3:0]                        port_c_change_enable;
    mode_cfg_pkg::drive_cfg_type       port_drive_config;
    logic [3:0]                        port_a_direction;
    logic [3:0]                        port_b_direction;
    logic                              timer0_count_en;
    logic                              timer1_count_en;
    logic                              modulated_freq_pin;
    logic [6:0]                        indirect_page_base;
    logic                              port_c_change_event;
    logic [3:0]                        port_a_out;
    logic [3:0]                        port_a_oe;
    logic [3:0]                        port_b_out;
    logic [3:0]                        port_b_oe;
    int                                fails;
    int                                n_compared;
    int                                cnt;

    mode_cfg_bank dut (
        .sys_clk(sys_clk), .rstn(rstn), .load_req(load_req), .mfp_gen_wave(mfp_gen_wave),
        .timer1_freq_out(timer1_freq_out), .port_c_pin0_clock_in(port_c_pin0_clock_in),
        .port_c_in(port_c_in), .port_a_data(port_a_data), .port_b_data(port_b_data),
        .timer0_mode(timer0_mode), .timer1_mode(timer1_mode), .indirect_page_select(indirect_page_select),
        .port_c_change_enable(port_c_change_enable), .port_drive_config(port_drive_config),
        .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
        .timer0_count_en(timer0_count_en), .timer1_count_en(timer1_count_en),
        .modulated_freq_pin(modulated_freq_pin), .indirect_page_base(indirect_page_base),
        .port_c_change_event(port_c_change_event), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
        .port_b_out(port_b_out), .port_b_oe(port_b_oe)
    );

    // -------------------------------------------------------------------
    // Clock, stimulus defaults and hang guard
    // -------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 1'b0;
        load_req = '0;
        mfp_gen_wave = 1'b0;
        timer1_freq_out = 1'b0;
        port_c_pin0_clock_in = 1'b1;
        port_c_in = 4'h0;
        port_a_data = 4'h0;
        port_b_data = 4'h0;
    end

    initial begin
        #2500000;
        fails++;
        end_of_test();
    end

    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_cnt(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc

    // Upper opcode bits carry junk so that only the low nibble may land
    task automatic load(input logic [2:0] tgt, input logic [3:0] val);
        @(posedge sys_clk);
        load_req <= '{en: 1'b1, target: mode_cfg_pkg::load_target_type'(tgt), opcode: {12'ha5c, val}};
        @(posedge sys_clk);
        load_req <= '0;
        #1;
    endtask : load

    function automatic logic [3:0] reg_of(input logic [2:0] tgt);
        case (tgt)
            3'h0:    return timer0_mode;
            3'h1:    return timer1_mode;
            3'h2:    return indirect_page_select;
            3'h3:    return port_c_change_enable;
            3'h4:    return port_drive_config;
            3'h5:    return port_a_direction;
            default: return port_b_direction;
        endcase
    endfunction : reg_of

    // Counts high samples of one pulse output over a window of whole cycles
    task automatic count(input int sel, input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            if ((sel == 0 && timer0_count_en === 1'b1) || (sel == 1 && timer1_count_en === 1'b1) ||
                (sel == 2 && port_c_change_event === 1'b1)) c++;
        end
    endtask : count

    task automatic do_reset();
        @(posedge sys_clk);
        rstn <= 1'b0;
        wait_cyc(3);
        for (int t = 0; t < 7; t++) begin
            chk_val("reset value", (t >= 5) ? 8'h0f : 8'h00, {4'h0, reg_of(t[2:0])});
        end
        chk_val("port a oe at reset", 8'h00, {4'h0, port_a_oe});
        @(posedge sys_clk);
        rstn <= 1'b1;
    endtask : do_reset

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        do_reset();
        // Every target, with reserved bits set and clear; timer0 and page drop reserved bits
        for (int t = 0; t < 7; t++) begin
            load(t[2:0], 4'hf);
            chk_val("load f", (t == 0) ? 8'h09 : (t == 2) ? 8'h07 : 8'h0f, {4'h0, reg_of(t[2:0])});
            load(t[2:0], 4'h6);
            chk_val("load 6", (t == 0) ? 8'h00 : 8'h06, {4'h0, reg_of(t[2:0])});
        end
        load(3'h7, 4'h1);
        chk_val("unused target", 8'h06, {4'h0, port_b_direction});
        chk_val("c pull-up", 8'h01, {7'h0, port_drive_config.c_pullup});
        chk_val("d pull-up", 8'h00, {7'h0, port_drive_config.d_pullup});
        // Page base for every page
        for (int p = 0; p < 8; p++) begin
            load(3'h2, p[3:0]);
            wait_cyc(1);
            chk_val("page base", p * 16, {1'b0, indirect_page_base});
        end
        // Timer0: stopped, then osc/4, then osc/1024
        load(3'h0, 4'h1);
        count(0, 1100, cnt);
        chk_cnt("timer0 stopped", 0, cnt);
        load(3'h0, 4'h8);
        wait_cyc(4);
        count(0, 40, cnt);
        chk_cnt("timer0 fast", 10, cnt);
        load(3'h0, 4'h9);
        wait_cyc(1030);
        count(0, 2048, cnt);
        chk_cnt("timer0 slow", 2, cnt);
        // Timer1: stopped, osc, osc/64, pin clock
        load(3'h1, 4'h0);
        count(1, 100, cnt);
        chk_cnt("timer1 stopped", 0, cnt);
        load(3'h1, 4'h8);
        wait_cyc(3);
        count(1, 20, cnt);
        chk_cnt("timer1 osc", 20, cnt);
        load(3'h1, 4'h9);
        wait_cyc(70);
        count(1, 128, cnt);
        chk_cnt("timer1 osc/64", 2, cnt);
        load(3'h1, 4'ha);
        wait_cyc(8);
        fork
            count(1, 40, cnt);
            repeat (3) begin
                @(posedge sys_clk) port_c_pin0_clock_in <= 1'b0;
                repeat (5) @(posedge sys_clk);
                port_c_pin0_clock_in <= 1'b1;
                repeat (4) @(posedge sys_clk);
            end
        join
        chk_cnt("timer1 pin clock", 3, cnt);
        // Output pin routing, with the two sources always opposite
        for (int m = 0; m < 4; m++) begin
            load(3'h1, m[1] ? 4'h4 : 4'h0);
            @(posedge sys_clk);
            mfp_gen_wave <= m[0];
            timer1_freq_out <= ~m[0];
            wait_cyc(3);
            chk_val("output pin", {7'h0, m[0] ^ m[1]}, {7'h0, modulated_freq_pin});
        end
        // Port C change: only enabled pins raise the event
        load(3'h3, 4'h4);
        wait_cyc(2);
        fork
            count(2, 10, cnt);
            @(posedge sys_clk) port_c_in <= 4'h2;
        join
        chk_cnt("masked change", 0, cnt);
        fork
            count(2, 10, cnt);
            @(posedge sys_clk) port_c_in <= 4'h6;
        join
        chk_cnt("enabled change", 1, cnt);
        // Pads: per-pin direction, push-pull then open-drain
        load(3'h5, 4'h5);
        load(3'h6, 4'h3);
        @(posedge sys_clk);
        port_a_data <= 4'h6;
        port_b_data <= 4'h9;
        load(3'h4, 4'h0);
        wait_cyc(2);
        chk_val("port a oe cmos", 8'h0a, {4'h0, port_a_oe});
        chk_val("port b oe cmos", 8'h0c, {4'h0, port_b_oe});
        chk_val("port a out", 8'h02, {4'h0, port_a_out & port_a_oe});
        chk_val("port b out", 8'h09, {4'h0, port_b_out});
        load(3'h4, 4'h3);
        wait_cyc(2);
        chk_val("port a oe open-drain", 8'h08, {4'h0, port_a_oe});
        chk_val("port b oe open-drain", 8'h04, {4'h0, port_b_oe});
        // Second reset in mid-run restores defaults
        do_reset();
        wait_cyc(2);
        chk_val("port b oe after reset", 8'h00, {4'h0, port_b_oe});
        end_of_test();
    end

endmodule : mode_cfg_bank_tb_top

`default_nettype wire
